// ==== logic/lin_actual_param_readout.sv ====
// Readout of the working parameter set over LIN diagnostic frames.
// Assumes a LIN byte controller on clk that flags breaks, hands over
// received bytes and takes bytes to send with a valid/ready handshake,
// filtering the echo of its own transmission.
//
// What this block does
// - Two requests, each answered by own response
// - Request: id 3c, app 80, cmd 82/83
// - Part two: off-diagonals, enable, freq, thermal, group
// - Part one: working colours, diagonals, fading
// - Fuse set: readout requests are ignored
`timescale 1ns/10ps
module lin_actual_param_readout (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // LIN byte receiver
  input wire logic rx_break,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // LIN byte transmitter
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Working colour values
  input wire logic [7:0] colour_1,
  input wire logic [7:0] colour_2,
  input wire logic [7:0] colour_3,
  // Working calibration matrix
  input wire logic [7:0] cal_a11,
  input wire logic [7:0] cal_a12,
  input wire logic [7:0] cal_a13,
  input wire logic [7:0] cal_a21,
  input wire logic [7:0] cal_a22,
  input wire logic [7:0] cal_a23,
  input wire logic [7:0] cal_a31,
  input wire logic [7:0] cal_a32,
  input wire logic [7:0] cal_a33,
  // Working fading and mode settings
  input wire logic fading_enable,
  input wire logic fading_slope,
  input wire logic [5:0] fading_time,
  input wire logic calibration_enable,
  input wire logic modulation_frequency_select,
  input wire logic thermal_control_bit,
  input wire logic [3:0] node_group_number
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  readout_pkg::frame_state_e state_r; // Frame sequencer
  logic [1:0] pend_r;                 // Answer owed to next response
  logic [3:0] ridx_r;                 // Received byte index
  logic [3:0] tidx_r;                 // Sent byte index
  logic [7:0] app_r;                  // Request data byte 1
  logic [7:0] cmd_r;                  // Request data byte 2
  logic [7:0] addr_r;                 // Request data byte 3
  logic [5:0] node_address_r;         // Own node address
  logic command_disable_fuse_r;       // Command disable fuse
  logic [7:0] err_cnt_r;              // Bad request checksums
  logic tx_valid_r;
  logic [7:0] tx_data_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic load;                         // Start of an answer
  logic tx_take;                      // Byte handed to transmitter
  logic req_ok;                       // Request fields match
  logic [3:0] sel;                    // Index of next answer byte
  logic [7:0] resp_byte;              // Answer byte at sel
  csum_if rx_cs ();
  csum_if tx_cs ();

  ////////////////////////////////////////////////////////////////////////
  // Checksum accumulators, one per direction
  lin_checksum rx_sum (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .c(rx_cs.engine)
  );

  lin_checksum tx_sum (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .c(tx_cs.engine)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of the received request
  always_comb begin
    // Identifier is not part of the sum
    rx_cs.clear = (state_r == readout_pkg::ST_PID) && rx_valid;
    rx_cs.add = (state_r == readout_pkg::ST_REQ) && rx_valid
                && (ridx_r < readout_pkg::DATA_BYTES);
    rx_cs.data = rx_data;
    req_ok = (app_r == readout_pkg::APP_COMMAND)
             && cmd_r[7]
             && (addr_r[7:6] == readout_pkg::ADDR_TOP_BITS)
             && (addr_r[5:0] == node_address_r)
             && !command_disable_fuse_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer byte selection
  always_comb begin
    load = (state_r == readout_pkg::ST_PID) && rx_valid && !rx_break
           && (rx_data == readout_pkg::PID_RESPONSE)
           && (pend_r != readout_pkg::PEND_NONE);
    tx_take = (state_r == readout_pkg::ST_RESP) && tx_valid_r && tx_ready;
    sel = load ? 4'h0 : tidx_r + 4'h1;
    resp_byte = {readout_pkg::ADDR_TOP_BITS, node_address_r};
    if (pend_r == readout_pkg::PEND_PART1) begin
      // Working values, not stored defaults
      case (sel)
        4'h1: resp_byte = colour_1;
        4'h2: resp_byte = colour_2;
        4'h3: resp_byte = colour_3;
        4'h4: resp_byte = cal_a11;
        4'h5: resp_byte = cal_a22;
        4'h6: resp_byte = cal_a33;
        4'h7: resp_byte = {fading_enable, fading_slope, fading_time};
        default: resp_byte = {readout_pkg::ADDR_TOP_BITS, node_address_r};
      endcase
    end else begin
      case (sel)
        4'h1: resp_byte = cal_a12;
        4'h2: resp_byte = cal_a13;
        4'h3: resp_byte = cal_a21;
        4'h4: resp_byte = cal_a23;
        4'h5: resp_byte = cal_a31;
        4'h6: resp_byte = cal_a32;
        4'h7: resp_byte = {calibration_enable, modulation_frequency_select,
                           1'b1, thermal_control_bit, node_group_number};
        default: resp_byte = {readout_pkg::ADDR_TOP_BITS, node_address_r};
      endcase
    end
    tx_cs.clear = load;
    tx_cs.add = load || (tx_take && (tidx_r < readout_pkg::LAST_DATA_IDX));
    tx_cs.data = resp_byte;
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= readout_pkg::ST_IDLE;
    end else if (ce) begin
      if (rx_break) begin
        // A new header aborts whatever was going on
        state_r <= readout_pkg::ST_PID;
      end else begin
        case (state_r)
          readout_pkg::ST_PID: begin
            if (rx_valid && rx_data == readout_pkg::PID_REQUEST) begin
              state_r <= readout_pkg::ST_REQ;
            end else if (load) begin
              state_r <= readout_pkg::ST_RESP;
            end else if (rx_valid) begin
              state_r <= readout_pkg::ST_IDLE;
            end
          end
          readout_pkg::ST_REQ: begin
            if (rx_valid && ridx_r == readout_pkg::DATA_BYTES) begin
              state_r <= readout_pkg::ST_IDLE;
            end
          end
          readout_pkg::ST_RESP: begin
            if (tx_take && tidx_r == readout_pkg::DATA_BYTES) begin
              state_r <= readout_pkg::ST_IDLE;
            end
          end
          default: state_r <= readout_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request byte capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ridx_r <= 4'h0;
      app_r <= 8'h00;
      cmd_r <= 8'h00;
      addr_r <= 8'h00;
    end else if (ce) begin
      if (state_r != readout_pkg::ST_REQ) begin
        ridx_r <= 4'h0;
      end else if (rx_valid && !rx_break) begin
        ridx_r <= ridx_r + 4'h1;
        case (ridx_r)
          4'h0: app_r <= rx_data;
          4'h1: cmd_r <= rx_data;
          4'h2: addr_r <= rx_data;
          default: ;  // Filler bytes and checksum are not kept
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Owed answer: one per accepted request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_r <= readout_pkg::PEND_NONE;
    end else if (ce) begin
      if (rx_break) begin
        pend_r <= pend_r;  // Kept until the next identifier is seen
      end else if (state_r == readout_pkg::ST_PID && rx_valid
                   && !load) begin
        // Any other frame drops the owed answer
        pend_r <= readout_pkg::PEND_NONE;
      end else if (tx_take && tidx_r == readout_pkg::DATA_BYTES) begin
        pend_r <= readout_pkg::PEND_NONE;
      end else if (state_r == readout_pkg::ST_REQ && rx_valid
                   && ridx_r == readout_pkg::DATA_BYTES
                   && rx_data == ~rx_cs.sum && req_ok) begin
        // Valid checksum and fields: decide which half to send
        if (cmd_r[6:0] == readout_pkg::CMD_PART1) begin
          pend_r <= readout_pkg::PEND_PART1;
        end else if (cmd_r[6:0] == readout_pkg::CMD_PART2) begin
          pend_r <= readout_pkg::PEND_PART2;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bad checksum counter, saturating
  always_ff @(posedge clk) begin
    if (!resetn) begin
      err_cnt_r <= 8'h00;
    end else if (ce) begin
      if (state_r == readout_pkg::ST_REQ && rx_valid && !rx_break
          && ridx_r == readout_pkg::DATA_BYTES
          && rx_data != ~rx_cs.sum && err_cnt_r != 8'hff) begin
        err_cnt_r <= err_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer transmitter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tidx_r <= 4'h0;
    end else if (ce) begin
      if (rx_break) begin
        tx_valid_r <= 1'b0;  // Abort on a new header
      end else if (load) begin
        tx_valid_r <= 1'b1;
        tx_data_r <= resp_byte;
        tidx_r <= 4'h0;
      end else if (tx_take) begin
        tidx_r <= tidx_r + 4'h1;
        if (tidx_r == readout_pkg::DATA_BYTES) begin
          tx_valid_r <= 1'b0;
        end else if (tidx_r == readout_pkg::LAST_DATA_IDX) begin
          tx_data_r <= ~tx_cs.sum;
        end else begin
          tx_data_r <= resp_byte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon handshake: waitrequest drops for one cycle per request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_r <= 1'b1;
    end else if (ce) begin
      wait_r <= !((avs_read || avs_write) && wait_r);
    end
  end

  // Configuration writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      node_address_r <= readout_pkg::CFG_ADDR_RESET;
      command_disable_fuse_r <= readout_pkg::CFG_FUSE_RESET;
    end else if (ce) begin
      if (avs_write && !wait_r && avs_address == readout_pkg::REG_CONFIG)
      begin
        node_address_r <= avs_writedata[readout_pkg::CFG_ADDR_LSB +: 6];
        command_disable_fuse_r <= avs_writedata[readout_pkg::CFG_FUSE_BIT];
      end
    end
  end

  // Read data, unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      if (avs_read && wait_r) begin
        rdata_r <= 32'h0000_0000;
        case (avs_address)
          readout_pkg::REG_CONFIG: begin
            rdata_r[readout_pkg::CFG_ADDR_LSB +: 6] <= node_address_r;
            rdata_r[readout_pkg::CFG_FUSE_BIT] <= command_disable_fuse_r;
          end
          readout_pkg::REG_STATUS: begin
            rdata_r[readout_pkg::ST_PEND_LSB +: 2] <= pend_r;
            rdata_r[readout_pkg::ST_BUSY_BIT] <= tx_valid_r;
            rdata_r[readout_pkg::ST_ERRCNT_LSB +: 8] <= err_cnt_r;
          end
          default: ;  // Unmapped
        endcase
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;

endmodule

// ==== logic/readout_pkg.sv ====
// Constants, state type and register map of the parameter readout block.
// Assumes a byte-level LIN controller on the same clock around the block.
package readout_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Frame identifiers and command codes
  localparam logic [7:0] PID_REQUEST = 8'h3c;  // Diagnostic request frame
  localparam logic [7:0] PID_RESPONSE = 8'h7d; // Slave response frame
  localparam logic [7:0] APP_COMMAND = 8'h80;  // Application command byte
  localparam logic [6:0] CMD_PART1 = 7'h02;    // First half of the set
  localparam logic [6:0] CMD_PART2 = 7'h03;    // Second half of the set
  localparam logic [1:0] ADDR_TOP_BITS = 2'h3; // Fixed top bits of byte 3
  localparam logic [3:0] DATA_BYTES = 4'h8;    // Data bytes per frame
  localparam logic [3:0] LAST_DATA_IDX = 4'h7; // Index of data byte 8

  ////////////////////////////////////////////////////////////////////////
  // Pending answer kinds
  localparam logic [1:0] PEND_NONE = 2'h0;
  localparam logic [1:0] PEND_PART1 = 2'h1;
  localparam logic [1:0] PEND_PART2 = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [3:0] REG_CONFIG = 4'h0; // Node address and fuse
  localparam logic [3:0] REG_STATUS = 4'h4; // Pending kind, busy, errors
  localparam int CFG_ADDR_LSB = 0;          // Node address [5:0]
  localparam int CFG_FUSE_BIT = 8;          // Command disable fuse
  localparam int ST_PEND_LSB = 0;           // Pending kind [1:0]
  localparam int ST_BUSY_BIT = 2;           // Answer being sent
  localparam int ST_ERRCNT_LSB = 8;         // Checksum error count [7:0]
  localparam logic [5:0] CFG_ADDR_RESET = 6'h00;
  localparam logic CFG_FUSE_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PID,
    ST_REQ,
    ST_RESP
  } frame_state_e;

endpackage

// ==== logic/csum_if.sv ====
// Carrier between the sequencer and a checksum accumulator.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface csum_if;
  logic clear;      // Start a new sum
  logic add;        // Add data to the sum
  logic [7:0] data; // Byte to add
  logic [7:0] sum;  // Running carry-wrapped sum
  modport engine (input clear, input add, input data, output sum);
  modport user (output clear, output add, output data, input sum);
endinterface

// ==== logic/lin_checksum.sv ====
// Classic LIN checksum accumulator: eight-bit sum with carry wrap.
// Assumes the user drives clear and add from logic on the same clock.
`timescale 1ns/10ps
module lin_checksum (
  // Clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Accumulator port
  csum_if.engine c
);

  logic [7:0] sum_r;  // Running sum
  logic [7:0] base;   // Sum that the new byte adds to
  logic [8:0] total;  // Sum with carry out
  logic [7:0] sum_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Carry-wrapped addition, clear restarting from zero
  always_comb begin
    base = c.clear ? 8'h00 : sum_r;
    total = {1'b0, base} + {1'b0, c.data};
    sum_nxt = total[7:0] + {7'h00, total[8]};
  end

  // Sum register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sum_r <= 8'h00;
    end else if (ce) begin
      if (c.add) begin
        sum_r <= sum_nxt;
      end else if (c.clear) begin
        sum_r <= 8'h00;
      end
    end
  end

  assign c.sum = sum_r;

endmodule

// ==== test/readout_props.sv ====
// Port checks for the parameter readout block.
// Assumes bind onto the block, ce high while bus or answer traffic runs.
`timescale 1ns/10ps
module readout_props (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // LIN bytes
  input wire logic rx_break,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [3:0] cnt_r; // Answer bytes taken
  logic [7:0] sum_r; // Sum of those bytes
  logic [8:0] acc; // Sum with carry out
  logic take; // Byte handed over
  assign take = tx_valid && tx_ready;
  assign acc = {1'b0, sum_r} + {1'b0, tx_data};
  ////////////////////////////////////////////////////////////////////////
  // Count and sum answer bytes since the last break
  always_ff @(posedge clk) begin
    if (!resetn || rx_break) begin
      cnt_r <= 4'h0;
      sum_r <= 8'h00;
    end else if (take) begin
      cnt_r <= cnt_r + 4'h1;
      sum_r <= acc[7:0] + {7'h00, acc[8]}; // Carry wrap
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_tx_hold: assert property (
    tx_valid && !tx_ready && !rx_break |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before taken");
  chk_start_id: assert property (
    $rose(tx_valid) |-> $past(rx_valid) && !$past(rx_break)
      && $past(rx_data) == readout_pkg::PID_RESPONSE)
    else $error("answer started without response id");
  chk_first_hdr: assert property (
    $rose(tx_valid) |-> tx_data[7:6] == 2'h3)
    else $error("first answer byte lacks top bits");
  chk_break_abort: assert property (rx_break |=> !tx_valid)
    else $error("answer kept after break");
  chk_frame_len: assert property (tx_valid |-> cnt_r < 4'h9)
    else $error("more than nine answer bytes");
  chk_csum_byte: assert property (
    take && cnt_r == 4'h8 |-> tx_data == ~sum_r)
    else $error("answer checksum wrong");
  chk_tx_release: assert property (
    take && cnt_r == 4'h8 |=> !tx_valid)
    else $error("tx valid after checksum");
  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  // Main scenarios reached
  cover property (take && cnt_r == 4'h8);
  cover property ($rose(tx_valid));
  cover property ((avs_read || avs_write) && !avs_waitrequest);
endmodule

// ==== test/lin_master_model.sv ====
// Behavioural LIN master byte controller facing the readout block.
// Assumes the same clock; the bench calls req for each exchange.
`timescale 1ns/10ps
module lin_master_model (
  // Clock
  input wire logic clk,
  // Bytes from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Bytes to the block
  output logic rx_break,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] got [0:15]; // Answer bytes seen
  int n; // Count of them
  logic slow; // Stall the transmitter
  logic [3:0] ph_r; // Stall pattern
  initial begin
    rx_break = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    slow = 1'b0;
    n = 0;
    ph_r = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Take answer bytes, prompt or stalling
  always @(posedge clk) begin
    ph_r <= ph_r + 4'h1;
    tx_ready <= slow ? ph_r[1] : 1'b1;
    if (tx_valid && tx_ready && n < 16) begin
      got[n] <= tx_data;
      n <= n + 1;
    end
  end
  // One byte or break for a cycle, then an idle cycle
  task automatic put(input logic brk, input logic [7:0] b);
    @(posedge clk);
    rx_break <= brk;
    rx_valid <= !brk;
    rx_data <= brk ? ~rx_data : b;
    @(posedge clk);
    rx_break <= 1'b0;
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  // Request frame, then response header and collection
  task automatic req(input logic [7:0] b1, b2, b3, input logic bad);
    logic [7:0] d [8];
    logic [7:0] s;
    logic [8:0] t; // Sum with carry out
    d = '{b1, b2, b3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    s = 8'h00;
    put(1'b1, 8'h00);
    put(1'b0, readout_pkg::PID_REQUEST);
    for (int i = 0; i < 8; i++) begin
      put(1'b0, d[i]);
      t = {1'b0, s} + {1'b0, d[i]};
      s = t[7:0] + {7'h00, t[8]}; // Classic carry wrap
    end
    put(1'b0, bad ? s : ~s);
    put(1'b1, 8'h00);
    put(1'b0, readout_pkg::PID_RESPONSE);
    n = 0;
    repeat (40) @(posedge clk);
  endtask
endmodule

// ==== test/tb_lin_actual_param_readout.sv ====
// Self-checking bench for the parameter readout block.
// Assumes the LIN master model and the port checker beside it.
`timescale 1ns/10ps
module tb_lin_actual_param_readout;
  logic clk, resetn, ce;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic rx_break, rx_valid, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data, m, q;
  logic [7:0] p [0:11]; // Colours then a11..a33
  logic [5:0] adr; // Node address in use
  int mismatches, num_checks;
  integer seed;
  lin_actual_param_readout lin_actual_param_readout_i (
    .clk(clk), .resetn(resetn), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_break(rx_break), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .colour_1(p[0]), .colour_2(p[1]), .colour_3(p[2]),
    .cal_a11(p[3]), .cal_a12(p[4]), .cal_a13(p[5]), .cal_a21(p[6]),
    .cal_a22(p[7]), .cal_a23(p[8]), .cal_a31(p[9]), .cal_a32(p[10]),
    .cal_a33(p[11]), .fading_enable(m[7]), .fading_slope(m[6]),
    .fading_time(m[5:0]), .calibration_enable(q[7]),
    .modulation_frequency_select(q[6]), .thermal_control_bit(q[4]),
    .node_group_number(q[3:0]));
  lin_master_model model_i (.clk(clk), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_break(rx_break),
    .rx_valid(rx_valid), .rx_data(rx_data));
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      // Bus limit ran out
      mismatches++;
      $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One exchange; part 0 means no answer is owed
  task automatic run(input logic [7:0] b1, b2, b3, input logic bad,
                     input int part);
    logic [7:0] e [9];
    logic [7:0] s;
    logic [8:0] t; // Sum with carry out
    model_i.req(b1, b2, b3, bad);
    if (part == 1) begin
      e = '{{2'h3, adr}, p[0], p[1], p[2], p[3], p[7], p[11], m, 8'h00};
    end else begin
      e = '{{2'h3, adr}, p[4], p[5], p[6], p[8], p[9], p[10],
            {q[7:6], 1'b1, q[4:0]}, 8'h00};
    end
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      t = {1'b0, s} + {1'b0, e[i]};
      s = t[7:0] + {7'h00, t[8]}; // Classic carry wrap
    end
    e[8] = ~s;
    check("resp_len", (part != 0) ? 32'h9 : 32'h0, model_i.n);
    for (int i = 0; i < 9 && part != 0; i++) begin
      check("resp_byte", e[i], model_i.got[i]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h0fe04946;
    resetn = 1'b0;
    ce = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    m = 8'h00;
    q = 8'h00;
    for (int j = 0; j < 12; j++) begin
      p[j] = 8'h00;
    end
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, readout_pkg::REG_STATUS, 32'h0, rd);
    check("status_reset", 32'h0, rd);
    adr = 6'($random(seed));
    bus(1'b1, readout_pkg::REG_CONFIG, {26'h0, adr}, rd);
    bus(1'b0, readout_pkg::REG_CONFIG, 32'h0, rd);
    check("config", {26'h0, adr}, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 12; j++) begin
        p[j] <= 8'($random(seed));
      end
      m <= 8'($random(seed));
      q <= 8'($random(seed));
      model_i.slow = i[0];
      run(8'h80, 8'h82, {2'h3, adr}, 1'b0, 1);
      run(8'h80, 8'h83, {2'h3, adr}, 1'b0, 2);
    end
    $display("test readout done");
    run(8'h80, 8'h82, {2'h3, adr ^ 6'h01}, 1'b0, 0);
    run(8'h81, 8'h82, {2'h3, adr}, 1'b0, 0);
    run(8'h80, 8'h84, {2'h3, adr}, 1'b0, 0);
    run(8'h80, 8'h02, {2'h3, adr}, 1'b0, 0);
    run(8'h80, 8'h82, {2'h1, adr}, 1'b0, 0);
    run(8'h80, 8'h83, {2'h3, adr}, 1'b1, 0);
    bus(1'b0, readout_pkg::REG_STATUS, 32'h0, rd);
    check("err_count", 32'h100, rd);
    $display("test refusals done");
    // Frozen block neither takes the request nor answers
    ce <= 1'b0;
    run(8'h80, 8'h82, {2'h3, adr}, 1'b0, 0);
    ce <= 1'b1;
    $display("test enable done");
    bus(1'b1, readout_pkg::REG_CONFIG, {23'h0, 1'b1, 2'h0, adr}, rd);
    run(8'h80, 8'h82, {2'h3, adr}, 1'b0, 0);
    bus(1'b1, readout_pkg::REG_CONFIG, {26'h0, adr}, rd);
    run(8'h80, 8'h82, {2'h3, adr}, 1'b0, 1);
    $display("test fuse done");
    summarize();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
bind lin_actual_param_readout readout_props readout_props_i (
  .clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .rx_break(rx_break), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
